// *** logic/cwd_cfg.svh ***
// Offsets, field positions, reset values and timing counts for the
// character-word instruction decoder. Included by its bare name.
`ifndef CWD_CFG_SVH
`define CWD_CFG_SVH

// Register port offsets
`define CWD_REG_CTRL 4'h0
`define CWD_REG_STATUS 4'h1
`define CWD_REG_PC 4'h2
`define CWD_REG_TIMER 4'h3
`define CWD_REG_PEND 4'h4
`define CWD_REG_DATA_LO 4'h5
`define CWD_REG_DATA_HI 4'h6

// Control and status bit positions
`define CWD_CTRL_RUN 0
`define CWD_CTRL_IEN 1
`define CWD_ST_PAR 0
`define CWD_ST_ILL 1
`define CWD_ST_IEN 2
`define CWD_ST_BUSY 3

// Instruction fields inside the 32 data bits; parity travels apart
`define CWD_OP_HI 31
`define CWD_OP_LO 26
`define CWD_U_BIT 25
`define CWD_R_HI 24
`define CWD_R_LO 22
`define CWD_I_BIT 21
`define CWD_X_HI 20
`define CWD_X_LO 18
`define CWD_WC_HI 17
`define CWD_WC_LO 0

// Interrupt save word: program counter low, one-hot cause above it
`define CWD_CAUSE_LSB 16
`define CWD_IRQ_SAVE_ADDR 16'h0000
`define CWD_IRQ_NEXT_PC 16'h0001

// Opcodes of the two interrupt-enabling instructions and legal opcodes
`define CWD_OP_IEN_A 6'h3E
`define CWD_OP_IEN_B 6'h3F
`define CWD_LEGAL_OPS 64'hFFFF_FFFF_FFFF_FFFE

// Reset value and timer width
`define CWD_PC_RST 16'h0000
`define CWD_TIMER_W 20

// Timing: clock period and timer tick period in ns
`define CWD_CLK_PERIOD_NS 10
`define CWD_TICK_PERIOD_NS 1000
`define CWD_TICK_CYCLES (`CWD_TICK_PERIOD_NS / `CWD_CLK_PERIOD_NS)

`endif

// *** logic/cwd_pkg.sv ***
// Types used by the decoder alone; its bench uses plain values.
// Assumes cwd_cfg.svh supplies all numeric constants.
package cwd_pkg;
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_FETCH = 6'b000010,
    S_DECODE = 6'b000100,
    S_INDIR = 6'b001000,
    S_EXEC = 6'b010000,
    S_IRQ = 6'b100000
  } cwd_state_t;
  typedef enum logic [1:0] {
    M_MEM = 2'h0,
    M_REG = 2'h1,
    M_IMM = 2'h2
  } cwd_mode_t;
endpackage

// *** logic/cwd_decoder.sv ***
// Instruction fetch, decode, operand address resolution, interval timer
// and interrupt entry for a 32-bit word, character addressed processor.
// Assumes a core memory on the same clock that grants access when free.
//
// Notes on behaviour
// - Words carry 32 data bits plus parity.
// - Four bytes, character 4 high, parity lowest.
// - One-word instruction, fixed field layout.
// - Six-bit opcode; unassigned codes are errors.
// - R selects one of eight data registers.
// - I clear direct address; set fetch indirect.
// - X 2..7 with I indexes before indirection.
// - Indirection repeats until I clear, indexing each.
// - X 0 none, 1 immediate, else add index.
// - 16-bit word address plus 2-bit character.
// - Four 8-bit index registers, two paired 16-bit.
// - Parity checked on every memory word, error flagged.
// - Odd parity over the 32 data bits.
// - Illegal instruction raises an error indication.
// - Timer, I/O end, disk and host interrupts.
// - Loadable 20-bit interval timer.
// - Timer counts down at 1 MHz, interrupts at zero.
// - Interrupt saves PC and cause at 0, fetches 1.
// - Interrupts blocked until an enabling instruction.
// - Memory bus shared; other masters steal cycles.
// - One shared adder for indexing and PC increment.
`timescale 1ns/10ps
`include "cwd_cfg.svh"

module cwd_decoder #(
  parameter int TIMER_W = `CWD_TIMER_W,
  parameter int TICK_CYCLES = `CWD_TICK_CYCLES,
  parameter logic [63:0] LEGAL_OPS = `CWD_LEGAL_OPS
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic mem_wpar,
  input wire logic mem_gnt,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_rpar,
  output logic dec_valid,
  output logic [5:0] dec_op,
  output logic dec_u,
  output logic [2:0] dec_r,
  output logic [17:0] dec_ea,
  output logic [1:0] dec_mode,
  output logic [7:0] dec_operand,
  input wire logic exec_done,
  input wire logic exec_pc_load,
  input wire logic [15:0] exec_pc_addr,
  input wire logic io_done_pin,
  input wire logic disk_a_req_pin,
  input wire logic disk_b_req_pin,
  input wire logic host_req_pin,
  output logic err_parity,
  output logic err_illegal,
  output logic int_enabled
);
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  cwd_pkg::cwd_state_t state;
  logic run;
  logic [15:0] pc;
  logic wait_rd;
  logic ind_i;
  logic [2:0] ind_x;
  logic [17:0] wc;
  logic [7:0] drg [0:7];
  logic [TIMER_W-1:0] timer_cnt;
  logic [TICK_W-1:0] tick_div;
  logic tick;
  logic [4:0] pend;
  logic [4:0] pend_set;
  logic [4:0] pend_clr;
  logic [4:0] cause;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic [3:0] req_lvl;
  logic [3:0] req_rise;
  logic [17:0] add_a;
  logic [17:0] add_b;
  logic [17:0] add_sum;
  logic [17:0] idx_val;
  logic irq_go;
  logic rd_ok;
  logic sw_wr_pend;
  logic sw_wr_stat;

  // Odd parity: data bits plus parity bit hold an odd count of ones
  assign rd_ok = ^{mem_rdata, mem_rpar};
  assign irq_go = int_enabled && (|pend) && run;
  assign sw_wr_pend = reg_wr && (reg_addr == `CWD_REG_PEND);
  assign sw_wr_stat = reg_wr && (reg_addr == `CWD_REG_STATUS);

  // Index register selection: C..F are 8-bit, A:B and G:H are paired
  always_comb begin
    idx_val = 18'h00000;
    unique case (ind_x)
      3'h2, 3'h3, 3'h4, 3'h5: idx_val = {10'h000, drg[ind_x]};
      3'h6: idx_val = {2'h0, drg[0], drg[1]};
      3'h7: idx_val = {2'h0, drg[6], drg[7]};
      3'h0, 3'h1: idx_val = 18'h00000;
    endcase
  end

  // One adder serves the program counter step and address modification
  always_comb begin
    add_a = wc;
    add_b = idx_val;
    if (state == cwd_pkg::S_FETCH) begin
      add_a = {2'h0, pc};
      add_b = 18'h00001;
    end
    add_sum = add_a + add_b;
  end

  // Memory bus: other masters steal cycles by holding off the grant
  always_comb begin
    mem_req = 1'b0;
    mem_we = 1'b0;
    mem_addr = pc;
    unique case (state)
      cwd_pkg::S_FETCH: mem_req = !wait_rd && run && !irq_go;
      cwd_pkg::S_INDIR: begin
        mem_req = !wait_rd;
        mem_addr = wc[17:2];
      end
      cwd_pkg::S_IRQ: begin
        mem_req = 1'b1;
        mem_we = 1'b1;
        mem_addr = `CWD_IRQ_SAVE_ADDR;
      end
      cwd_pkg::S_IDLE, cwd_pkg::S_DECODE, cwd_pkg::S_EXEC: mem_req = 1'b0;
    endcase
  end

  // Lowest numbered pending source is taken first
  always_comb begin
    cause = 5'h00;
    for (int k = 4; k >= 0; k--) begin
      if (pend[k]) begin
        cause = 5'h00;
        cause[k] = 1'b1;
      end
    end
  end

  // Pin synchronisers; only the first rise after reset counts, once stages two and three agree
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
      req_lvl <= 4'h0;
    end else begin
      sync1 <= {host_req_pin, disk_b_req_pin, disk_a_req_pin, io_done_pin};
      sync2 <= sync1;
      sync3 <= sync2;
      req_lvl <= (req_lvl & ~(sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3)) |
                 (req_lvl & (sync2 ^ sync3));
    end
  end
  assign req_rise = sync3 & ~(sync2 ^ sync3) & ~req_lvl;

  // 1 MHz enable from the system clock
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tick_div <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_div == TICK_LAST);
      if (tick_div == TICK_LAST) begin
        tick_div <= '0;
      end else begin
        tick_div <= tick_div + TICK_W'(1);
      end
    end
  end

  // Interval timer; a load of zero never raises an interrupt
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      timer_cnt <= '0;
    end else if (reg_wr && (reg_addr == `CWD_REG_TIMER)) begin
      timer_cnt <= reg_wdata[TIMER_W-1:0];
    end else if (tick && (timer_cnt != '0)) begin
      timer_cnt <= timer_cnt - TIMER_W'(1);
    end
  end

  // Pending sources: timer, I/O end, disk A, disk B, host
  always_comb begin
    pend_set = {req_rise, tick && (timer_cnt == TIMER_W'(1))};
    pend_clr = sw_wr_pend ? reg_wdata[4:0] : 5'h00;
    if (state == cwd_pkg::S_IRQ && mem_gnt) begin
      pend_clr = pend_clr | cause;
    end
  end

  // A new event in the clearing cycle survives
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pend <= 5'h00;
    end else begin
      pend <= (pend & ~pend_clr) | pend_set;
    end
  end

  // Error flags: sticky, write one to clear, set wins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      err_parity <= 1'b0;
      err_illegal <= 1'b0;
    end else begin
      err_parity <= (err_parity && !(sw_wr_stat && reg_wdata[`CWD_ST_PAR])) ||
                    (mem_rvalid && wait_rd && !rd_ok);
      err_illegal <= (err_illegal && !(sw_wr_stat && reg_wdata[`CWD_ST_ILL])) ||
                     (state == cwd_pkg::S_DECODE && !LEGAL_OPS[dec_op]);
    end
  end

  // Interrupt enable: blocked on entry, reopened by an enabling opcode
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      int_enabled <= 1'b0;
    end else if (state == cwd_pkg::S_IRQ && mem_gnt) begin
      int_enabled <= 1'b0;
    end else if (state == cwd_pkg::S_EXEC && exec_done &&
                 (dec_op == `CWD_OP_IEN_A || dec_op == `CWD_OP_IEN_B)) begin
      int_enabled <= 1'b1;
    end else if (reg_wr && reg_addr == `CWD_REG_CTRL) begin
      int_enabled <= reg_wdata[`CWD_CTRL_IEN];
    end
  end

  // Run control and the data registers, both software loaded
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      run <= 1'b0;
      for (int k = 0; k < 8; k++) begin
        drg[k] <= 8'h00;
      end
    end else if (reg_wr) begin
      if (reg_addr == `CWD_REG_CTRL) begin
        run <= reg_wdata[`CWD_CTRL_RUN];
      end
      if (reg_addr == `CWD_REG_DATA_LO) begin
        for (int k = 0; k < 4; k++) begin
          drg[k] <= reg_wdata[8*k +: 8];
        end
      end
      if (reg_addr == `CWD_REG_DATA_HI) begin
        for (int k = 0; k < 4; k++) begin
          drg[k+4] <= reg_wdata[8*k +: 8];
        end
      end
    end
  end

  // Program counter
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pc <= `CWD_PC_RST;
    end else if (state == cwd_pkg::S_FETCH && mem_req && mem_gnt) begin
      pc <= add_sum[15:0];
    end else if (state == cwd_pkg::S_EXEC && exec_done && exec_pc_load) begin
      pc <= exec_pc_addr;
    end else if (state == cwd_pkg::S_IRQ && mem_gnt) begin
      pc <= `CWD_IRQ_NEXT_PC;
    end else if (state == cwd_pkg::S_IDLE && reg_wr && reg_addr == `CWD_REG_PC) begin
      pc <= reg_wdata[15:0];
    end
  end

  // Save word for interrupt entry, captured when the entry is chosen
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mem_wdata <= 32'h0000_0000;
      mem_wpar <= 1'b1;
    end else if (state == cwd_pkg::S_FETCH && !wait_rd && irq_go) begin
      mem_wdata <= {11'h000, cause, pc};
      mem_wpar <= ~^{11'h000, cause, pc};
    end
  end

  // Sequencer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= cwd_pkg::S_IDLE;
      wait_rd <= 1'b0;
      ind_i <= 1'b0;
      ind_x <= 3'h0;
      wc <= 18'h00000;
      dec_op <= 6'h00;
      dec_u <= 1'b0;
      dec_r <= 3'h0;
      dec_ea <= 18'h00000;
      dec_mode <= cwd_pkg::M_MEM;
      dec_operand <= 8'h00;
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= 1'b0;
      unique case (state)
        cwd_pkg::S_IDLE: begin
          if (run) begin
            state <= cwd_pkg::S_FETCH;
          end
        end
        cwd_pkg::S_FETCH: begin
          if (wait_rd) begin
            if (mem_rvalid) begin
              wait_rd <= 1'b0;
              dec_op <= mem_rdata[`CWD_OP_HI:`CWD_OP_LO];
              dec_u <= mem_rdata[`CWD_U_BIT];
              dec_r <= mem_rdata[`CWD_R_HI:`CWD_R_LO];
              ind_i <= mem_rdata[`CWD_I_BIT];
              ind_x <= mem_rdata[`CWD_X_HI:`CWD_X_LO];
              wc <= mem_rdata[`CWD_WC_HI:`CWD_WC_LO];
              state <= cwd_pkg::S_DECODE;
            end
          end else if (!run) begin
            state <= cwd_pkg::S_IDLE;
          end else if (irq_go) begin
            state <= cwd_pkg::S_IRQ;
          end else if (mem_gnt) begin
            wait_rd <= 1'b1;
          end
        end
        cwd_pkg::S_DECODE: begin
          if (!LEGAL_OPS[dec_op]) begin
            state <= cwd_pkg::S_FETCH;
          end else if (wc == 18'h00000) begin
            dec_mode <= cwd_pkg::M_REG;
            dec_operand <= drg[ind_x];
            dec_ea <= 18'h00000;
            dec_valid <= 1'b1;
            state <= cwd_pkg::S_EXEC;
          end else if (ind_i) begin
            wc <= add_sum;
            state <= cwd_pkg::S_INDIR;
          end else if (ind_x == 3'h1) begin
            dec_mode <= cwd_pkg::M_IMM;
            dec_operand <= wc[7:0];
            dec_ea <= wc;
            dec_valid <= 1'b1;
            state <= cwd_pkg::S_EXEC;
          end else begin
            dec_mode <= cwd_pkg::M_MEM;
            dec_ea <= add_sum;
            dec_operand <= 8'h00;
            dec_valid <= 1'b1;
            state <= cwd_pkg::S_EXEC;
          end
        end
        cwd_pkg::S_INDIR: begin
          if (wait_rd) begin
            if (mem_rvalid) begin
              wait_rd <= 1'b0;
              ind_i <= mem_rdata[`CWD_I_BIT];
              ind_x <= mem_rdata[`CWD_X_HI:`CWD_X_LO];
              wc <= mem_rdata[`CWD_WC_HI:`CWD_WC_LO];
              state <= cwd_pkg::S_DECODE;
            end
          end else if (mem_gnt) begin
            wait_rd <= 1'b1;
          end
        end
        cwd_pkg::S_EXEC: begin
          if (exec_done) begin
            state <= run ? cwd_pkg::S_FETCH : cwd_pkg::S_IDLE;
          end
        end
        cwd_pkg::S_IRQ: begin
          if (mem_gnt) begin
            state <= cwd_pkg::S_FETCH;
          end
        end
      endcase
    end
  end

  // Register reads answer one cycle after the strobe; unmapped read zero
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `CWD_REG_CTRL: reg_rdata <= {30'h0, int_enabled, run};
        `CWD_REG_STATUS: reg_rdata <= {28'h0, state != cwd_pkg::S_IDLE,
                                       int_enabled, err_illegal, err_parity};
        `CWD_REG_PC: reg_rdata <= {16'h0000, pc};
        `CWD_REG_TIMER: reg_rdata <= {{(32-TIMER_W){1'b0}}, timer_cnt};
        `CWD_REG_PEND: reg_rdata <= {27'h0, pend};
        `CWD_REG_DATA_LO: reg_rdata <= {drg[3], drg[2], drg[1], drg[0]};
        `CWD_REG_DATA_HI: reg_rdata <= {drg[7], drg[6], drg[5], drg[4]};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule // cwd_decoder

// *** tb/cwd_decoder_assertions.sv ***
// Checker for the decoder's memory port, decode outputs and parity error flag.
// Assumes it is bound onto cwd_decoder and sees a single clock domain.
`timescale 1ns/10ps
`include "cwd_cfg.svh"
module cwd_decoder_assertions #(
  parameter logic [63:0] LEGAL_OPS = `CWD_LEGAL_OPS
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_wpar,
  input wire logic mem_gnt,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_rpar,
  input wire logic dec_valid,
  input wire logic [5:0] dec_op,
  input wire logic [17:0] dec_ea,
  input wire logic [1:0] dec_mode,
  input wire logic err_parity,
  input wire logic int_enabled
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // Interrupt entry is a granted save write followed by a fetch of word one
  sequence s_save;
    mem_req && mem_we && mem_gnt;
  endsequence
  sequence s_fetch1;
    ##[1:3] mem_req && !mem_we && mem_addr == 16'h0001;
  endsequence
  property p_wpar;
    mem_req && mem_we |-> mem_wpar == ~^mem_wdata;
  endproperty
  a_wpar: assert property (p_wpar) else $error("save word parity not odd");
  property p_rpar;
    mem_rvalid && !(^{mem_rdata, mem_rpar}) |=> err_parity;
  endproperty
  a_rpar: assert property (p_rpar) else $error("bad read parity not flagged");
  property p_save_addr;
    mem_req && mem_we |-> mem_addr == 16'h0000;
  endproperty
  a_save_addr: assert property (p_save_addr) else $error("save not at word zero");
  property p_vector;
    s_save |-> s_fetch1;
  endproperty
  a_vector: assert property (p_vector) else $error("no fetch from word one");
  property p_block;
    s_save |=> !int_enabled;
  endproperty
  a_block: assert property (p_block) else $error("interrupts left open");
  property p_en_first;
    mem_req && mem_we |-> int_enabled;
  endproperty
  a_en_first: assert property (p_en_first) else $error("entry while blocked");
  property p_legal;
    dec_valid |-> LEGAL_OPS[dec_op];
  endproperty
  a_legal: assert property (p_legal) else $error("illegal opcode presented");
  property p_regmode;
    dec_valid && dec_mode == 2'h1 |-> dec_ea == 18'h00000;
  endproperty
  a_regmode: assert property (p_regmode) else $error("register mode with address");
  // Stolen cycles must not disturb a waiting request
  property p_hold;
    mem_req && !mem_gnt |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped while stolen");
endmodule // cwd_decoder_assertions

bind cwd_decoder cwd_decoder_assertions #(.LEGAL_OPS(LEGAL_OPS)) u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wpar(mem_wpar),
  .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
  .mem_rpar(mem_rpar), .dec_valid(dec_valid), .dec_op(dec_op), .dec_ea(dec_ea),
  .dec_mode(dec_mode), .err_parity(err_parity), .int_enabled(int_enabled)
);

// *** tb/cwd_mem_model.sv ***
// Behavioural core memory, 256 words of 32 data bits plus parity.
// Assumes one outstanding access; slow mode steals cycles and delays reads.
`timescale 1ns/10ps
module cwd_mem_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_wpar,
  input wire logic slow,
  output logic mem_gnt,
  output logic mem_rvalid,
  output logic [31:0] mem_rdata,
  output logic mem_rpar
);
  logic [32:0] mem [0:255];
  logic [32:0] last;
  logic steal;
  logic busy;
  logic [1:0] wait_n;
  // Other bus masters take every second cycle in slow mode
  assign mem_gnt = mem_req && !(slow && steal);
  // Released bus shows the inverse, never the held value
  assign mem_rdata = mem_rvalid ? last[32:1] : ~last[32:1];
  assign mem_rpar = mem_rvalid ? last[0] : ~last[0];
  // Plain always: the bench preloads the array from its own process
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      steal <= 1'b0;
      busy <= 1'b0;
      wait_n <= 2'h0;
      mem_rvalid <= 1'b0;
      last <= 33'h0;
    end else begin
      steal <= ~steal;
      mem_rvalid <= 1'b0;
      if (mem_req && mem_gnt) begin
        if (mem_we) begin
          mem[mem_addr[7:0]] <= {mem_wdata, mem_wpar};
        end else begin
          last <= mem[mem_addr[7:0]];
          busy <= 1'b1;
          wait_n <= slow ? 2'h2 : 2'h0;
        end
      end else if (busy) begin
        if (wait_n == 2'h0) begin
          mem_rvalid <= 1'b1;
          busy <= 1'b0;
        end else begin
          wait_n <= wait_n - 2'h1;
        end
      end
    end
  end
endmodule // cwd_mem_model

// *** tb/testbench.sv ***
// Self-checking bench: register port tasks, a small program in the memory
// model, and an executor that finishes each instruction one cycle later.
`timescale 1ns/10ps
`include "cwd_cfg.svh"
module testbench;
  logic clk_sys, rstn, reg_wr, reg_rd, slow, exec_done, host_req_pin;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mem_wdata, mem_rdata;
  logic mem_req, mem_we, mem_wpar, mem_gnt, mem_rvalid, mem_rpar;
  logic [15:0] mem_addr;
  logic dec_valid, err_parity, err_illegal, int_enabled, dec_u;
  logic [2:0] dec_r;
  logic [5:0] dec_op;
  logic [17:0] dec_ea;
  logic [1:0] dec_mode;
  logic [7:0] dec_operand;
  int n_mismatch, n_checks, cyc;

  // Short tick keeps the timer test brief; I/O end shares the host pin stimulus
  cwd_decoder #(.TICK_CYCLES(4)) DUT (
    .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wpar(mem_wpar),
    .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .mem_rpar(mem_rpar), .dec_valid(dec_valid), .dec_op(dec_op), .dec_u(dec_u),
    .dec_r(dec_r), .dec_ea(dec_ea), .dec_mode(dec_mode), .dec_operand(dec_operand),
    .exec_done(exec_done), .exec_pc_load(1'b0), .exec_pc_addr(16'h0000),
    .io_done_pin(host_req_pin), .disk_a_req_pin(1'b0), .disk_b_req_pin(1'b0),
    .host_req_pin(host_req_pin), .err_parity(err_parity),
    .err_illegal(err_illegal), .int_enabled(int_enabled)
  );
  cwd_mem_model u_mem (
    .clk_sys(clk_sys), .rstn(rstn), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wpar(mem_wpar), .slow(slow),
    .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .mem_rpar(mem_rpar)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    exec_done <= dec_valid;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("unexpected at %0t: run did not finish in time", $time);
      stop_test();
    end
  end

  function automatic logic [32:0] w(input logic [5:0] op, input logic i,
      input logic [2:0] x, input logic [17:0] wc, input logic bad);
    logic [31:0] d;
    // U and R follow the opcode so every instruction carries its own values
    d = {op, op[0], op[2:0], i, x, wc};
    return {d, ~^d ^ bad};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, exp);
  endtask
  // Wait for the next decoded instruction and compare its fields
  task automatic dec(input logic [5:0] op, input logic [1:0] md,
      input logic [17:0] ea, input logic [7:0] opnd);
    int i;
    i = 0;
    do begin
      @(negedge clk_sys);
      i++;
    end while (dec_valid !== 1'b1 && i < 300);
    chk(32'(dec_op), 32'(op));
    chk(32'(dec_u), 32'(op[0]));
    chk(32'(dec_r), 32'(op[2:0]));
    chk(32'(dec_mode), 32'(md));
    if (md != 2'h2) chk(32'(dec_ea), 32'(ea));
    if (md != 2'h0) chk(32'(dec_operand), 32'(opnd));
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    slow = 1'b0;
    exec_done = 1'b0;
    host_req_pin = 1'b0;
    n_mismatch = 0;
    n_checks = 0;
    cyc = 0;
    for (int k = 0; k < 256; k++) u_mem.mem[k] = w(6'h06, 1'b0, 3'h0, 18'h00004, 1'b0);
    u_mem.mem[8'h01] = w(6'h06, 1'b0, 3'h6, 18'h00010, 1'b0);
    u_mem.mem[8'h10] = w(6'h01, 1'b0, 3'h0, 18'h00101, 1'b0);
    u_mem.mem[8'h11] = w(6'h02, 1'b0, 3'h1, 18'h000A5, 1'b0);
    u_mem.mem[8'h12] = w(6'h03, 1'b0, 3'h3, 18'h00000, 1'b0);
    u_mem.mem[8'h13] = w(6'h04, 1'b1, 3'h2, 18'h00100, 1'b0);
    u_mem.mem[8'h4C] = w(6'h04, 1'b1, 3'h3, 18'h00200, 1'b0);
    u_mem.mem[8'h91] = w(6'h04, 1'b0, 3'h0, 18'h03002, 1'b0);
    u_mem.mem[8'h14] = w(6'h00, 1'b0, 3'h0, 18'h00004, 1'b0);
    u_mem.mem[8'h15] = w(6'h05, 1'b0, 3'h0, 18'h00020, 1'b1);
    u_mem.mem[8'h16] = w(6'h3E, 1'b0, 3'h0, 18'h00004, 1'b0);
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(4'h0, 32'h0);
    rd(4'h1, 32'h0);
    rd(4'h4, 32'h0);
    rd(4'hF, 32'h0);
    wr(4'h5, 32'h44332211);
    wr(4'h6, 32'h88776655);
    rd(4'h5, 32'h44332211);
    $display("reset and register test done");
    wr(4'h3, 32'h2);
    repeat (20) @(posedge clk_sys);
    host_req_pin <= 1'b1;
    repeat (3) @(posedge clk_sys);
    host_req_pin <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(4'h4, 32'h13);
    rd(4'h3, 32'h0);
    $display("timer test done");
    wr(4'h2, 32'h10);
    wr(4'h0, 32'h1);
    dec(6'h01, 2'h0, 18'h00101, 8'h00);
    @(posedge clk_sys);
    slow <= 1'b1;
    dec(6'h02, 2'h2, 18'h0, 8'hA5);
    dec(6'h03, 2'h1, 18'h0, 8'h44);
    dec(6'h04, 2'h0, 18'h03002, 8'h00);
    dec(6'h05, 2'h0, 18'h00020, 8'h00);
    chk(32'(err_illegal), 32'h1);
    chk(32'(err_parity), 32'h1);
    $display("decode test done");
    dec(6'h3E, 2'h0, 18'h00004, 8'h00);
    dec(6'h06, 2'h0, 18'h01132, 8'h00);
    chk(32'(int_enabled), 32'h0);
    chk(u_mem.mem[0][32:1], 32'h00010017);
    chk(32'(u_mem.mem[0][0]), 32'(~^32'h00010017));
    rd(4'h4, 32'h12);
    rd(4'h1, 32'hB);
    wr(4'h1, 32'h3);
    rd(4'h1, 32'h8);
    $display("interrupt test done");
    stop_test();
  end
endmodule // testbench
